// ### port_irq_pkg.sv
`default_nettype none
package port_irq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_G0_BUF_SEL  = 16'h5204;
  localparam logic [15:0] IDX_G0_IRQ_EN   = 16'h5205;
  localparam logic [15:0] IDX_G0_EDGE     = 16'h5206;
  localparam logic [15:0] IDX_G0_FLAGS    = 16'h5207;
  localparam logic [15:0] IDX_G0_DEBOUNCE = 16'h5208;
  localparam logic [15:0] IDX_G1_BUF_SEL  = 16'h5214;
  localparam logic [15:0] IDX_G1_IRQ_EN   = 16'h5215;
  localparam logic [15:0] IDX_G1_EDGE     = 16'h5216;
  localparam logic [15:0] IDX_G1_FLAGS    = 16'h5217;

  // Values after reset
  localparam logic [15:0] BUF_SEL_RESET  = 16'hffff;
  localparam logic [15:0] IRQ_EN_RESET   = 16'h0000;
  localparam logic [15:0] EDGE_RESET     = 16'h0000;
  localparam logic [15:0] FLAGS_RESET    = 16'h0000;
  localparam logic [15:0] SYNC_RESET     = 16'h0000;
  localparam logic [2:0]  FILTER_RESET   = 3'h0;
  localparam logic [3:0]  NIBBLE_RESET   = 4'h0;

  // Debounce control field positions
  localparam int LO_FILTER_LSB = 0;
  localparam int HI_FILTER_LSB = 4;

  // Check time of code 1 in pclk cycles; each code above doubles it
  localparam int unsigned FILTER_BASE_CYCLES = 256;
  localparam int          CNT_W              = 15;
  localparam logic [2:0]  FILTER_OFF         = 3'h0;

  // State of the port logic, apart from the two nibble filters
  typedef struct packed {
    logic [15:0] sync_a;
    logic [15:0] sync_b;
    logic [15:0] prev;
    logic [15:0] buf_sel;
    logic [15:0] irq_en;
    logic [15:0] edge_sel;
    logic [15:0] flag;
    logic [2:0]  filt_hi;
    logic [2:0]  filt_lo;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        irq0;
    logic        irq1;
  } port_state_s;

  // Whole state of one nibble filter
  typedef struct packed {
    logic [3:0]            level;
    logic [3:0][CNT_W-1:0] cnt;
  } nibble_state_s;

  // Byte address of a register index
  function automatic logic [31:0] reg_addr(input logic [15:0] idx);
    return {14'h0000, idx, 2'b00};
  endfunction

  // Stable cycles needed before a new level is accepted
  function automatic logic [CNT_W-1:0] check_cycles(input logic [2:0] code,
                                                    input int unsigned base);
    int unsigned full;
    full = base << (code - 3'h1);
    return CNT_W'(full);
  endfunction

endpackage
`default_nettype wire

// ### nibble_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module nibble_debounce
  import port_irq_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = FILTER_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Synchronised pins and check time code
  input  wire logic [3:0] raw,
  input  wire logic [2:0] code,
  // Filtered levels
  output logic      [3:0] level
);

  nibble_state_s s_reg;
  nibble_state_s s_next;
  logic [CNT_W-1:0] limit;

  // Accept a level only after it stood a full check time
  always_comb begin
    s_next = s_reg;
    limit  = check_cycles(code, BASE_CYCLES);
    for (int i = 0; i < 4; i++) begin
      if (code == FILTER_OFF) begin
        s_next.level[i] = raw[i];
        s_next.cnt[i]   = '0;
      end else if (raw[i] == s_reg.level[i]) begin
        s_next.cnt[i] = '0;
      end else if (s_reg.cnt[i] >= limit - CNT_W'(1)) begin // Shorter code, counter above it
        s_next.level[i] = raw[i];
        s_next.cnt[i]   = '0;
      end else begin
        s_next.cnt[i] = s_reg.cnt[i] + CNT_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg       <= '0;
      s_reg.level <= NIBBLE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.level;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_filter_bypass_follows: assert property (
    code == FILTER_OFF && $past(code) == FILTER_OFF |-> level == $past(raw))
    else $error("filter off but level does not follow input");

  a_filter_short_reject: assert property (
    code != FILTER_OFF && $stable(code) && $changed(level)
      |-> $past(s_reg.cnt[0]) >= limit - CNT_W'(1) || level[0] == $past(level[0]))
    else $error("filtered level changed before check time");

endmodule
`default_nettype wire

// ### port_input_interrupt_logic.sv
// Summary of operation
// - Buffer select bit 1 picks hysteresis input, 0 picks CMOS; resets to 1.
// - Every pin of both groups has an interrupt enable bit, reset 0.
// - Disabled pins never set their flag nor raise the group request.
// - Edge polarity bit 1 triggers on falling edge, 0 on rising.
// - Selected edge on an enabled pin sets its flag; all flags reset 0.
// - Any set flag raises its group request line in the same cycle.
// - Writing 1 clears a flag, 0 leaves it; reads show flags.
// - Group request is a level held while any group flag is set.
// - Debounce bits 6:4 set group zero pins 7:4; bit 7 reserved.
// - Bits 2:0 set pins 3:0; codes 7..1 give 16384..256 clocks; 0 off.
// - Filter rejects pulses under check time, accepts after one check time.
`timescale 1ns/1ps
`default_nettype none
module port_input_interrupt_logic
  import port_irq_pkg::*;
#(
  parameter int unsigned CHECK_BASE_CYCLES = FILTER_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port pins, group zero in bits 7:0, group one in 15:8
  input  wire logic [15:0] pin_in,
  output logic      [15:0] input_buffer_select,
  // Requests to the system interrupt controller
  output logic             port_group_zero_irq,
  output logic             port_group_one_irq
);

  port_state_s s_reg;
  port_state_s s_next;

  logic [15:0] level;
  logic [3:0]  filt_lo_level;
  logic [3:0]  filt_hi_level;
  logic [15:0] rise_vec;
  logic [15:0] fall_vec;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [7:0]  rd_byte;
  logic        addr_hit;
  logic        wr_go;
  logic        setup;

  // Group zero nibble filters
  nibble_debounce #(
    .BASE_CYCLES (CHECK_BASE_CYCLES)
  ) u_filter_lo (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (s_reg.sync_b[3:0]),
    .code    (s_reg.filt_lo),
    .level   (filt_lo_level)
  );

  nibble_debounce #(
    .BASE_CYCLES (CHECK_BASE_CYCLES)
  ) u_filter_hi (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (s_reg.sync_b[7:4]),
    .code    (s_reg.filt_hi),
    .level   (filt_hi_level)
  );

  // Levels seen by edge detection
  assign level = {s_reg.sync_b[15:8], filt_hi_level, filt_lo_level};

  // Edge detection and flag set terms
  always_comb begin
    rise_vec = level & ~s_reg.prev;
    fall_vec = ~level & s_reg.prev;
    for (int i = 0; i < 16; i++) begin
      if (s_reg.edge_sel[i]) begin
        set_vec[i] = fall_vec[i] & s_reg.irq_en[i];
      end else begin
        set_vec[i] = rise_vec[i] & s_reg.irq_en[i];
      end
    end
  end

  // APB phase decode
  assign setup = psel & ~penable;
  assign wr_go = psel & penable & s_reg.ready & pwrite;

  // Address decode, read mux and clear mask
  always_comb begin
    addr_hit = 1'b1;
    rd_byte  = 8'h00;
    clr_vec  = 16'h0000;
    if (paddr == reg_addr(IDX_G0_BUF_SEL)) begin
      rd_byte = s_reg.buf_sel[7:0];
    end else if (paddr == reg_addr(IDX_G1_BUF_SEL)) begin
      rd_byte = s_reg.buf_sel[15:8];
    end else if (paddr == reg_addr(IDX_G0_IRQ_EN)) begin
      rd_byte = s_reg.irq_en[7:0];
    end else if (paddr == reg_addr(IDX_G1_IRQ_EN)) begin
      rd_byte = s_reg.irq_en[15:8];
    end else if (paddr == reg_addr(IDX_G0_EDGE)) begin
      rd_byte = s_reg.edge_sel[7:0];
    end else if (paddr == reg_addr(IDX_G1_EDGE)) begin
      rd_byte = s_reg.edge_sel[15:8];
    end else if (paddr == reg_addr(IDX_G0_FLAGS)) begin
      rd_byte = s_reg.flag[7:0];
      if (wr_go) begin
        clr_vec[7:0] = pwdata[7:0];
      end
    end else if (paddr == reg_addr(IDX_G1_FLAGS)) begin
      rd_byte = s_reg.flag[15:8];
      if (wr_go) begin
        clr_vec[15:8] = pwdata[7:0];
      end
    end else if (paddr == reg_addr(IDX_G0_DEBOUNCE)) begin
      rd_byte = {1'b0, s_reg.filt_hi, 1'b0, s_reg.filt_lo};
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    // Two-stage synchroniser, then previous level
    s_next.sync_a = pin_in;
    s_next.sync_b = s_reg.sync_a;
    s_next.prev   = level;
    // Zero-wait answer: ready and data for the access phase
    s_next.ready  = setup;
    s_next.slverr = setup & ~addr_hit;
    s_next.rdata  = setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    // Register writes at the completing edge
    if (wr_go) begin
      if (paddr == reg_addr(IDX_G0_BUF_SEL)) begin
        s_next.buf_sel[7:0] = pwdata[7:0];
      end
      if (paddr == reg_addr(IDX_G1_BUF_SEL)) begin
        s_next.buf_sel[15:8] = pwdata[7:0];
      end
      if (paddr == reg_addr(IDX_G0_IRQ_EN)) begin
        s_next.irq_en[7:0] = pwdata[7:0];
      end
      if (paddr == reg_addr(IDX_G1_IRQ_EN)) begin
        s_next.irq_en[15:8] = pwdata[7:0];
      end
      if (paddr == reg_addr(IDX_G0_EDGE)) begin
        s_next.edge_sel[7:0] = pwdata[7:0];
      end
      if (paddr == reg_addr(IDX_G1_EDGE)) begin
        s_next.edge_sel[15:8] = pwdata[7:0];
      end
      if (paddr == reg_addr(IDX_G0_DEBOUNCE)) begin
        s_next.filt_hi = pwdata[HI_FILTER_LSB +: 3];
        s_next.filt_lo = pwdata[LO_FILTER_LSB +: 3];
      end
    end
    // Set wins over a clear in the same cycle
    s_next.flag = (s_reg.flag & ~clr_vec) | set_vec;
    // Level requests follow the next flags, same edge as the set
    s_next.irq0 = |s_next.flag[7:0];
    s_next.irq1 = |s_next.flag[15:8];
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg          <= '0;
      s_reg.sync_a   <= SYNC_RESET;
      s_reg.sync_b   <= SYNC_RESET;
      s_reg.prev     <= SYNC_RESET;
      s_reg.buf_sel  <= BUF_SEL_RESET;
      s_reg.irq_en   <= IRQ_EN_RESET;
      s_reg.edge_sel <= EDGE_RESET;
      s_reg.flag     <= FLAGS_RESET;
      s_reg.filt_hi  <= FILTER_RESET;
      s_reg.filt_lo  <= FILTER_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign prdata              = s_reg.rdata;
  assign pready              = s_reg.ready;
  assign pslverr             = s_reg.slverr;
  assign input_buffer_select = s_reg.buf_sel;
  assign port_group_zero_irq = s_reg.irq0;
  assign port_group_one_irq  = s_reg.irq1;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completing write to a given register
  sequence s_write_to(logic [15:0] idx);
    psel && penable && pready && pwrite && paddr == reg_addr(idx);
  endsequence

  // Rising level on pin zero while enabled and rising selected
  sequence s_pin0_rise;
    s_reg.irq_en[0] && !s_reg.edge_sel[0] && level[0] && !s_reg.prev[0];
  endsequence

  // Falling level on pin eight while enabled and falling selected
  sequence s_pin8_fall;
    s_reg.irq_en[8] && s_reg.edge_sel[8] && !level[8] && s_reg.prev[8];
  endsequence

  a_flag_needs_enable: assert property (
    (s_reg.flag & ~$past(s_reg.flag) & ~$past(s_reg.irq_en)) == 16'h0000)
    else $error("flag set on a disabled pin");

  a_rise_sets_flag: assert property (
    s_pin0_rise |=> s_reg.flag[0] && port_group_zero_irq)
    else $error("rising edge did not set flag and request");

  a_fall_sets_flag: assert property (
    s_pin8_fall |=> s_reg.flag[8] && port_group_one_irq)
    else $error("falling edge did not set flag and request");

  a_irq_tracks_flags: assert property (
    port_group_zero_irq == (|s_reg.flag[7:0]) && port_group_one_irq == (|s_reg.flag[15:8]))
    else $error("group request differs from its flags");

  a_w1c_clears: assert property (
    s_write_to(IDX_G0_FLAGS) ##0 (pwdata[1] && !set_vec[1]) |=> !s_reg.flag[1])
    else $error("writing one did not clear the flag");

  a_w0_keeps: assert property (
    s_write_to(IDX_G1_FLAGS) ##0 (!pwdata[2] && s_reg.flag[10]) |=> s_reg.flag[10])
    else $error("writing zero changed a flag");

  a_set_beats_clear: assert property (
    s_write_to(IDX_G0_FLAGS) ##0 (pwdata[0] && set_vec[0]) |=> s_reg.flag[0])
    else $error("clear beat a simultaneous set");

  a_reserved_read_zero: assert property (
    psel && penable && pready && !pwrite && paddr == reg_addr(IDX_G0_DEBOUNCE)
      |-> prdata[7] == 1'b0 && prdata[3] == 1'b0)
    else $error("reserved debounce bits read nonzero");

  a_apb_zero_wait: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("answer not one cycle after setup");

  a_sync_two_stage: assert property (
    ##2 s_reg.sync_b == $past(pin_in, 2))
    else $error("synchroniser depth is not two");

  a_set_raises_zero: assert property (
    (|set_vec[7:0]) |=> port_group_zero_irq)
    else $error("group zero request missed a flag set");

  a_set_raises_one: assert property (
    (|set_vec[15:8]) |=> port_group_one_irq)
    else $error("group one request missed a flag set");

  a_edge_sets_flags: assert property (
    set_vec != 16'h0000 |=> (s_reg.flag & $past(set_vec)) == $past(set_vec))
    else $error("selected edge did not set its flag");

  a_flag_read_back: assert property (
    psel && !penable && paddr == reg_addr(IDX_G1_FLAGS)
      |=> prdata == {24'h00_0000, $past(s_reg.flag[15:8])})
    else $error("flag read differs from flag state");

  a_debounce_write: assert property (
    s_write_to(IDX_G0_DEBOUNCE)
      |=> s_reg.filt_hi == $past(pwdata[HI_FILTER_LSB +: 3])
        && s_reg.filt_lo == $past(pwdata[LO_FILTER_LSB +: 3]))
    else $error("debounce write not stored");

  a_buffer_select_write: assert property (
    s_write_to(IDX_G1_BUF_SEL) |=> input_buffer_select[15:8] == $past(pwdata[7:0]))
    else $error("buffer select write not shown on output");

  a_enable_write: assert property (
    s_write_to(IDX_G0_IRQ_EN) |=> s_reg.irq_en[7:0] == $past(pwdata[7:0]))
    else $error("enable write not stored");

  a_unmapped_error: assert property (
    psel && !penable && !addr_hit |=> pslverr && pready && prdata == 32'h0000_0000)
    else $error("unmapped access without error response");

  a_request_holds: assert property (
    port_group_one_irq && clr_vec[15:8] == 8'h00 |=> port_group_one_irq)
    else $error("group request dropped without a clear");

  a_polarity_gates_set: assert property (
    (set_vec & s_reg.edge_sel & ~fall_vec) == 16'h0000
      && (set_vec & ~s_reg.edge_sel & ~rise_vec) == 16'h0000)
    else $error("flag set on the unselected edge");

endmodule
`default_nettype wire

// ### switch_bank.sv
`timescale 1ns/1ps
`default_nettype none
module switch_bank (
  // Clock
  input  wire logic        pclk,
  // Levels on the port pins
  output logic      [15:0] pins
);
  // Switches start open, pins low
  initial pins = 16'h0000;

  // Move one pin just after an edge
  task automatic set_pin(input int p, input logic v);
    @(posedge pclk);
    pins[p] <= v;
  endtask

  // Contact bounce: flip a pin for w cycles, then back
  task automatic glitch(input int p, input int w);
    logic v;
    v = pins[p];
    set_pin(p, ~v);
    repeat (w - 1) @(posedge pclk);
    set_pin(p, v);
  endtask
endmodule
`default_nettype wire

// ### port_input_interrupt_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_input_interrupt_logic_tb
  import port_irq_pkg::*;
;
  localparam int unsigned BASE = 4;
  localparam logic [15:0] RIDX [9] = '{16'h5204, 16'h5205, 16'h5206, 16'h5207, 16'h5208,
                                       16'h5214, 16'h5215, 16'h5216, 16'h5217};
  localparam logic [7:0]  RRST [9] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
                                       8'hff, 8'h00, 8'h00, 8'h00};
  logic        pclk;
  logic        presetn;
  logic [31:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] pin_in;
  logic [15:0] input_buffer_select;
  logic        port_group_zero_irq;
  logic        port_group_one_irq;
  logic [31:0] rd;
  logic [31:0] v;
  logic        err;
  logic        pol;
  logic [1:0]  ctl_enable;
  logic [1:0]  cpu_req;
  int          mismatches;
  int          n_compared;
  int          p;
  int          ct;

  // Block under test and the switches on its pins
  port_input_interrupt_logic #(.CHECK_BASE_CYCLES(BASE)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .input_buffer_select(input_buffer_select),
    .port_group_zero_irq(port_group_zero_irq), .port_group_one_irq(port_group_one_irq));
  switch_bank sw (.pclk(pclk), .pins(pin_in));

  // Level-triggered controller model, group enables set by software
  always_comb cpu_req = {port_group_one_irq, port_group_zero_irq} & ctl_enable;

  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Expected values
  function automatic logic [7:0] pbit(input int q);
    return 8'h01 << (q % 8);
  endfunction
  function automatic logic [15:0] gidx(input int q, input logic [15:0] g0);
    return (q < 8) ? g0 : g0 + 16'h0010;
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0000, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Sample pready and data at the edge itself, before the slave updates
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h00_0000, exp});
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask

  // Verdict
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial begin
    #500000;
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    n_compared = 0;
    ctl_enable = 2'b11;
    void'($urandom(32'h3717932d));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle(0);
    chk({16'h0000, input_buffer_select}, 32'h0000_ffff);
    for (int i = 0; i < 9; i++) rdc(RIDX[i], RRST[i]);
    $display("reset values done");

    v = $urandom;
    apb(1'b1, IDX_G0_BUF_SEL, v[7:0]);
    apb(1'b1, IDX_G1_BUF_SEL, v[15:8]);
    #1;
    chk({16'h0000, input_buffer_select}, {16'h0000, v[15:0]});
    apb(1'b1, IDX_G1_EDGE, v[23:16]);
    rdc(IDX_G1_EDGE, v[23:16]);
    apb(1'b0, 16'h5209, 8'h00);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, IDX_G0_DEBOUNCE, 8'hff);
    rdc(IDX_G0_DEBOUNCE, 8'h77);
    apb(1'b1, IDX_G0_DEBOUNCE, 8'h00);
    $display("register access done");

    for (int i = 0; i < 16; i++) begin
      p = (i < 2) ? i * 15 : $urandom_range(15);
      pol = 1'($urandom_range(1));
      apb(1'b1, gidx(p, IDX_G0_IRQ_EN), 8'h00);
      sw.set_pin(p, pol);
      settle(6);
      apb(1'b1, gidx(p, IDX_G0_FLAGS), 8'hff);
      apb(1'b1, gidx(p, IDX_G0_EDGE), pol ? pbit(p) : 8'h00);
      apb(1'b1, gidx(p, IDX_G0_IRQ_EN), pbit(p));
      rdc(gidx(p, IDX_G0_IRQ_EN), pbit(p));
      sw.set_pin(p, ~pol);
      settle(6);
      chk({port_group_one_irq, port_group_zero_irq}, (p < 8) ? 2'b01 : 2'b10);
      rdc(gidx(p, IDX_G0_FLAGS), pbit(p));
      apb(1'b1, gidx(p, IDX_G0_FLAGS), ~pbit(p));
      rdc(gidx(p, IDX_G0_FLAGS), pbit(p));
      apb(1'b1, gidx(p, IDX_G0_FLAGS), pbit(p));
      #1;
      chk({port_group_one_irq, port_group_zero_irq}, 2'b00);
      chk(cpu_req, 2'b00);
      sw.set_pin(p, pol);
      settle(6);
      rdc(gidx(p, IDX_G0_FLAGS), 8'h00);
      apb(1'b1, gidx(p, IDX_G0_IRQ_EN), 8'h00);
      sw.set_pin(p, ~pol);
      settle(6);
      rdc(gidx(p, IDX_G0_FLAGS), 8'h00);
      chk({port_group_one_irq, port_group_zero_irq}, 2'b00);
    end
    $display("edge and flag done");

    // Group zero interrupts are all off while the filter changes
    apb(1'b1, IDX_G0_DEBOUNCE, 8'h21);
    apb(1'b1, IDX_G0_EDGE, 8'h00);
    for (int k = 0; k < 2; k++) begin
      p = k * 4;
      ct = BASE << k;
      sw.set_pin(p, 1'b0);
      settle(2 * ct + 6);
      apb(1'b1, IDX_G0_FLAGS, 8'hff);
      apb(1'b1, IDX_G0_IRQ_EN, pbit(p));
      sw.glitch(p, ct - 1);
      settle(2 * ct + 4);
      rdc(IDX_G0_FLAGS, 8'h00);
      sw.set_pin(p, 1'b1);
      settle(ct);
      chk({31'h0000_0000, port_group_zero_irq}, 32'h0000_0000);
      settle(ct + 6);
      rdc(IDX_G0_FLAGS, pbit(p));
      apb(1'b1, IDX_G0_IRQ_EN, 8'h00);
    end
    $display("filter done");
    close_out();
  end
endmodule
`default_nettype wire
